// File: design/dsie_exec.v
// decrement-and-skip execute stage
// assumes a fetched word each cycle and a one-cycle data memory read
`timescale 1ns/10ps
`include "dsie_consts.vh"
module dsie_exec
(
  input wire clock_i,
  input wire rst_i,
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire ext_en_i,
  input wire [3:0] bank_select_register_i,
  input wire [11:0] index_base_i,
  input wire [7:0] rdata_i,
  input wire [7:0] status_i,
  output reg [11:0] raddr_o,
  output reg [11:0] waddr_o,
  output reg [7:0] wdata_o,
  output reg we_o,
  output reg [7:0] wreg_o,
  output reg wreg_we_o,
  output reg squash_o,
  output reg indexed_o,
  output reg [7:0] status_o,
  output reg busy_o
);
// ****************************************
// decode
// ****************************************
  wire [5:0] opc = instr_i[`DSIE_OPC_HI:`DSIE_OPC_LO];
  wire is_skz = (opc == `DSIE_OPC_SKZ);
  wire is_sknz = (opc == `DSIE_OPC_SKNZ);
  wire hit = instr_valid_i && (is_skz || is_sknz);
  wire [11:0] addr;
  wire idx;
  dsie_addr u_addr
  (
    .faddr_i(instr_i[`DSIE_F_HI:`DSIE_F_LO]),
    .access_i(instr_i[`DSIE_A_BIT]),
    .ext_en_i(ext_en_i),
    .bank_select_register_i(bank_select_register_i),
    .index_base_i(index_base_i),
    .addr_o(addr),
    .indexed_o(idx)
  );
// ****************************************
// state
// ****************************************
  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_EXEC = 3'b010;
  localparam [2:0] S_NOP = 3'b100;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg skz_q;
  reg dest_q;
  wire [7:0] dec = rdata_i - `DSIE_ONE;
  wire zero = (dec == `DSIE_ZERO);
  // skip sense differs only in polarity
  wire skip = skz_q ? zero : !zero;
  always @*
  begin
    case (state_q)
      S_IDLE: state_d = hit ? S_EXEC : S_IDLE;
      S_EXEC: state_d = skip ? S_NOP : S_IDLE;
      S_NOP: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end
  // words seen while busy are dropped, not queued
  wire take = (state_q == S_IDLE) && hit;
  wire in_exec = (state_q == S_EXEC);
// ****************************************
// sequencer
// ****************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= S_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end
// ****************************************
// captured fields
// ****************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      skz_q <= 1'b0;
    end
    else if (take)
    begin
      skz_q <= is_skz;
    end
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dest_q <= `DSIE_DEST_FILE;
    end
    else if (take)
    begin
      dest_q <= instr_i[`DSIE_D_BIT];
    end
  end
// ****************************************
// operand address
// ****************************************
  // held until the next take so the memory read stays put
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      raddr_o <= `DSIE_RST_ADDR;
    end
    else if (take)
    begin
      raddr_o <= addr;
    end
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      indexed_o <= 1'b0;
    end
    else if (take)
    begin
      indexed_o <= idx;
    end
  end
// ****************************************
// file write
// ****************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      waddr_o <= `DSIE_RST_ADDR;
    end
    else if (in_exec && dest_q)
    begin
      waddr_o <= raddr_o;
    end
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wdata_o <= `DSIE_RST_BYTE;
    end
    else if (in_exec && dest_q)
    begin
      wdata_o <= dec;
    end
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      we_o <= 1'b0;
    end
    else
    begin
      we_o <= in_exec && dest_q;
    end
  end
// ****************************************
// accumulator write
// ****************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wreg_o <= `DSIE_RST_BYTE;
    end
    else if (in_exec && !dest_q)
    begin
      wreg_o <= dec;
    end
  end
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wreg_we_o <= 1'b0;
    end
    else
    begin
      wreg_we_o <= in_exec && !dest_q;
    end
  end
// ****************************************
// skip
// ****************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      squash_o <= 1'b0;
    end
    else
    begin
      squash_o <= in_exec && skip;
    end
  end
// ****************************************
// status
// ****************************************
  // flags pass through a register unchanged, one cycle late; neither form writes them
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      status_o <= `DSIE_RST_BYTE;
    end
    else
    begin
      status_o <= status_i;
    end
  end
// ****************************************
// busy
// ****************************************
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
    end
    else
    begin
      busy_o <= (state_d != S_IDLE);
    end
  end
endmodule // dsie_exec

// File: design/dsie_consts.vh
// constants for the decrement-and-skip execute block
// assumes a 16-bit instruction word and an 8-bit data path
// Overview of operation
// - the addressed file register is read, one is subtracted, and that value is both stored and tested.
// - the result goes to the working accumulator when the destination bit is 0, else back to the file register.
// - prefix 0010 11 decodes skip-if-zero and 0100 11 skip-if-nonzero, then destination bit, access bit and file address.
// - skip-if-zero discards the fetched next instruction when the result is zero, else lets it run.
// - skip-if-nonzero discards the fetched next instruction when the result is nonzero, else lets it run.
// - a skip runs a no_operation in place of the discarded instruction, so the instruction takes two cycles.
// - access bit 0 resolves the address in the access bank; access bit 1 uses the bank_select_register.
// - extended set enabled, access bit 0 and address at most 5Fh select indexed literal-offset addressing.
`ifndef DSIE_CONSTS_VH
`define DSIE_CONSTS_VH
// ****************************************
// instruction fields
// ****************************************
`define DSIE_OPC_HI 15
`define DSIE_OPC_LO 10
`define DSIE_OPC_SKZ 6'h0b
`define DSIE_OPC_SKNZ 6'h13
`define DSIE_A_BIT 8
`define DSIE_D_BIT 9
`define DSIE_F_HI 7
`define DSIE_F_LO 0
// ****************************************
// addressing and decrement constants
// ****************************************
`define DSIE_IDX_LIMIT 8'h5f
`define DSIE_ACC_SPLIT 8'h80
`define DSIE_ACC_LOW_BANK 4'h0
`define DSIE_ACC_HIGH_BANK 4'hf
`define DSIE_ONE 8'h01
`define DSIE_ZERO 8'h00
// ****************************************
// reset values
// ****************************************
`define DSIE_RST_ADDR 12'h000
`define DSIE_RST_BYTE 8'h00
`define DSIE_DEST_FILE 1'b1
`endif

// File: design/dsie_addr.v
// file address resolver for the decrement-and-skip block
// assumes bank select and indexed base are stable during decode
`timescale 1ns/10ps
`include "dsie_consts.vh"
module dsie_addr
(
  input wire [7:0] faddr_i,
  input wire access_i,
  input wire ext_en_i,
  input wire [3:0] bank_select_register_i,
  input wire [11:0] index_base_i,
  output reg [11:0] addr_o,
  output reg indexed_o
);
  always @*
  begin
    indexed_o = 1'b0;
    if (access_i)
      addr_o = {bank_select_register_i, faddr_i};
    else if (ext_en_i && (faddr_i <= `DSIE_IDX_LIMIT))
    begin
      // indexed base plus literal offset wraps in 12 bits
      indexed_o = 1'b1;
      addr_o = index_base_i + {4'h0, faddr_i};
    end
    else if (faddr_i < `DSIE_ACC_SPLIT)
      addr_o = {`DSIE_ACC_LOW_BANK, faddr_i};
    else
      addr_o = {`DSIE_ACC_HIGH_BANK, faddr_i};
  end
endmodule // dsie_addr

// File: sim/dsie_exec_asserts.sv
// assertions for the decrement-and-skip stage
// bound onto dsie_exec, sees only its ports
`timescale 1ns/10ps
module dsie_chk
(
  input wire clock_i,
  input wire rst_i,
  input wire [15:0] instr_i,
  input wire [7:0] rdata_i,
  input wire [11:0] waddr_o,
  input wire [7:0] wdata_o,
  input wire we_o,
  input wire [7:0] wreg_o,
  input wire wreg_we_o,
  input wire squash_o,
  input wire indexed_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  reg [15:0] iq;
  reg [7:0] rq;
  wire wr = we_o | wreg_we_o;
  // aligned with the strobes
  always @(posedge clock_i)
  begin
    iq <= $past(instr_i);
    rq <= rdata_i - 8'h01;
  end
  file_data_a:
    assert property (we_o |-> wdata_o == rq) else $error("file data");
  acc_data_a:
    assert property (wreg_we_o |-> wreg_o == rq) else $error("acc data");
  dest_sel_a:
    assert property (wr |-> we_o == iq[9]) else $error("destination");
  opc_ok_a:
    assert property (wr |-> iq[15:10] inside {6'h0b, 6'h13}) else $error("op");
  skip_when_a:
    assert property (wr |-> squash_o == (iq[14] ^ (rq == 0))) else $error("skip");
  nop_slot_a:
    assert property (squash_o |-> wr ##1 !(wr | squash_o)) else $error("nop");
  acc_bank_a:
    assert property (we_o && !iq[8] && !indexed_o |->
      waddr_o == {{4{iq[7]}}, iq[7:0]}) else $error("bank");
  idx_sel_a:
    assert property (wr && indexed_o |-> !iq[8] && iq[7:0] <= 8'h5f)
      else $error("index");
endmodule // dsie_chk
bind dsie_exec dsie_chk i_chk (.*);

// File: sim/tb_top.sv
// bench: random decrement-and-skip stream against a model
// assumes dsie_exec with its bound checker
`timescale 1ns/10ps
module tb_top;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg instr_valid_i = 1'b0;
  reg ext_en_i = 1'b0;
  reg [15:0] instr_i = 16'h0000;
  reg [3:0] bank_select_register_i = 4'h0;
  reg [11:0] index_base_i = 12'h000;
  reg [7:0] rdata_i = 8'h00;
  reg [7:0] status_i = 8'h00;
  reg [31:0] lf = 32'h214c;
  integer miscompares = 0;
  integer num_checks = 0;
  // reference model, one queued result per issued word
  integer hit, skip, ix, addr, res;
  integer exp_q[$];
  wire [11:0] raddr_o, waddr_o;
  wire [7:0] wdata_o, wreg_o, status_o;
  wire we_o, wreg_we_o, squash_o, indexed_o, busy_o;
  dsie_exec i_dut
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .ext_en_i(ext_en_i),
    .bank_select_register_i(bank_select_register_i),
    .index_base_i(index_base_i),
    .rdata_i(rdata_i),
    .status_i(status_i),
    .raddr_o(raddr_o),
    .waddr_o(waddr_o),
    .wdata_o(wdata_o),
    .we_o(we_o),
    .wreg_o(wreg_o),
    .wreg_we_o(wreg_we_o),
    .squash_o(squash_o),
    .indexed_o(indexed_o),
    .status_o(status_o),
    .busy_o(busy_o)
  );
  initial forever #25 clock_i = ~clock_i;
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input ok, input string msg);
    begin
      num_checks = num_checks + 1;
      if (ok !== 1'b1)
      begin
        $display("MISMATCH at %0t: %0s", $time, msg);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1 chk({raddr_o, waddr_o, wdata_o} === 32'h0, "reset bus");
    chk({wreg_o, status_o} === 16'h0, "reset byte");
    chk({we_o, wreg_we_o, squash_o} === 3'h0, "reset pulse");
    chk({indexed_o, busy_o} === 2'h0, "reset level");
    $display("reset test done");
    repeat (300)
    begin
      lf = nx(lf);
      @(posedge clock_i);
      // inputs other than instr_valid_i held for the whole instruction, read data included
      instr_valid_i <= lf[1:0] != 2'h3;
      instr_i <= {lf[0] ? 6'h13 : lf[1] ? 6'h0a : 6'h0b, lf[13:4]};
      {status_i, ext_en_i, bank_select_register_i, index_base_i} <=
        {lf[7:0], lf[30:14]};
      rdata_i <= lf[3] ? 8'h01 : lf[31:24];
      // model from the rules, fed from the settled inputs
      #1 hit = instr_valid_i && (instr_i[15:10] == 6'h0b ||
        instr_i[15:10] == 6'h13);
      res = (rdata_i + 255) % 256;
      skip = (instr_i[15:10] == 6'h0b) ? res == 0 : res != 0;
      ix = ext_en_i && !instr_i[8] && instr_i[7:0] <= 95;
      if (ix)
        addr = (index_base_i + instr_i[7:0]) % 4096;
      else if (instr_i[8])
        addr = bank_select_register_i * 256 + instr_i[7:0];
      else if (instr_i[7:0] < 128)
        addr = instr_i[7:0];
      else
        addr = 3840 + instr_i[7:0];
      exp_q.push_back(res);
      @(posedge clock_i);
      instr_valid_i <= 1'b0;
      #1 chk(busy_o === (hit != 0), "busy on take");
      if (hit)
      begin
        chk(raddr_o === addr[11:0], "operand address");
        chk(indexed_o === ix[0], "indexed");
      end
      @(posedge clock_i);
      #1 res = exp_q.pop_front();
      chk(we_o === (hit && instr_i[9]), "file strobe");
      chk(wreg_we_o === (hit && !instr_i[9]), "acc strobe");
      if (hit && instr_i[9])
        chk({waddr_o, wdata_o} === {addr[11:0], res[7:0]}, "file");
      if (hit && !instr_i[9])
        chk(wreg_o === res[7:0], "acc result");
      chk(squash_o === (hit && skip), "skip");
      chk(busy_o === (hit && skip), "busy in skip");
      chk(status_o === status_i, "status");
      @(posedge clock_i);
      #1 chk({we_o, wreg_we_o, squash_o} === 3'h0, "no_operation");
      chk(busy_o === 1'b0, "idle");
    end
    $display("random decrement-skip test done");
    close_out;
  end
endmodule // tb_top
